// [rtl/rcs_map.svh]
// Offsets, field positions, reset values and delay figures for the
// reset-cause and start-up controller. Definitions only.
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

`define RCS_ADR_RESET_CTRL  8'h00
`define RCS_ADR_OSC_CTRL    8'h04
`define RCS_ADR_BOR_CFG     8'h08

`define RCS_BIT_TRAP        15
`define RCS_BIT_ILLOP       14
`define RCS_BIT_PIN         7
`define RCS_BIT_SOFT        6
`define RCS_BIT_WDOG        4
`define RCS_BIT_SLEEP       3
`define RCS_BIT_IDLE        2
`define RCS_BIT_BOR         1
`define RCS_BIT_POR         0
`define RCS_BIT_OSC_LOCK    5
`define RCS_BIT_OSC_FAIL    3
`define RCS_BIT_BOR_EN      2

`define RCS_RESET_CTRL_RST  16'h0003
`define RCS_BOR_CFG_RST     3'h4
`define RCS_GRP_FRC         2'h2

`define RCS_VEC_RESET       24'h000000
`define RCS_VEC_CLKFAIL     24'h000004
`define RCS_PC_STEP         24'h000002

`define RCS_CLK_NS          40
`define RCS_POR_DELAY_NS    10000
`define RCS_FAILSAFE_NS     100000
`define RCS_POWERUP_TIMER_MS_A       4
`define RCS_POWERUP_TIMER_MS_B       16
`define RCS_POWERUP_TIMER_MS_C       64
`define RCS_NS_PER_MS       1000000
`define RCS_POR_CYC \
    ((`RCS_POR_DELAY_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`define RCS_FAILSAFE_CYC \
    ((`RCS_FAILSAFE_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)

`endif

// [rtl/rcs_pkg.sv]
// Types shared by the reset-cause and start-up controller.
// Assumes nothing beyond a SystemVerilog compiler.
package rcs_pkg;
    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_DELAY  = 3'b001,
        ST_STALL  = 3'b010,
        ST_WAITQ1 = 3'b011
    } rcs_state_e;
    typedef logic [20:0] rcs_count_t;
endpackage

// [rtl/rcs_reset_ctrl.sv]
// Reset sequencer and reset-cause register with a Wishbone slave.
// Assumes all inputs synchronous to clk, event inputs one-cycle pulses.
`timescale 1ns/1ps
`include "rcs_map.svh"

module rcs_reset_ctrl #(
    parameter int POWERUP_TIMER_A_CYC = `RCS_POWERUP_TIMER_MS_A * `RCS_NS_PER_MS / `RCS_CLK_NS,
    parameter int POWERUP_TIMER_B_CYC = `RCS_POWERUP_TIMER_MS_B * `RCS_NS_PER_MS / `RCS_CLK_NS,
    parameter int POWERUP_TIMER_C_CYC = `RCS_POWERUP_TIMER_MS_C * `RCS_NS_PER_MS / `RCS_CLK_NS
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        clkEn,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        powerOnEvent,
    input  wire logic [3:0]  brownoutBelow,
    input  wire logic        pinResetReq,
    input  wire logic        softResetReq,
    input  wire logic        watchdogTimeout,
    input  wire logic        illegalOpReq,
    input  wire logic        trapConflictReq,
    input  wire logic        inSleep,
    input  wire logic        inIdle,
    input  wire logic        interruptWake,
    input  wire logic [23:0] interruptVector,
    input  wire logic [23:0] pcCurrent,
    input  wire logic        failsafeClockMonitor,
    input  wire logic [1:0]  powerupTimerSel,
    input  wire logic [1:0]  oscGroupConfig,
    input  wire logic [3:0]  primaryOscModeConfig,
    input  wire logic        crystalMode,
    input  wire logic        pllUsed,
    input  wire logic        oscRunning,
    input  wire logic        oscStartupDone,
    input  wire logic        pllLocked,
    input  wire logic        firstPhaseClock,
    output logic             internalReset,
    output logic             clockHold,
    output logic             oscStartupStart,
    output logic             clockFailTrap,
    output logic [1:0]       clockSource,
    output logic [3:0]       primaryOscMode,
    output logic             pcLoad,
    output logic [23:0]      pcValue
);
    rcs_pkg::rcs_state_e stateReg;
    rcs_pkg::rcs_state_e stateNext;
    rcs_pkg::rcs_count_t delayReg;
    rcs_pkg::rcs_count_t delayNext;
    logic [15:0] flagsReg;
    logic [15:0] flagsNext;
    logic [15:0] flagsBase;
    logic [2:0]  borCfgReg;
    logic        failReg;
    logic [23:0] vectorReg;
    logic [23:0] vectorNext;
    logic        ackReg;
    logic [31:0] datReg;

    function automatic rcs_pkg::rcs_count_t delayFor(
        input logic [1:0] sel,
        input logic       xtal
    );
        int total;
        total = `RCS_POR_CYC;
        if (sel == 2'h1) begin
            total = total + POWERUP_TIMER_A_CYC;
        end else if (sel == 2'h2) begin
            total = total + POWERUP_TIMER_B_CYC;
        end else if (sel == 2'h3) begin
            total = total + POWERUP_TIMER_C_CYC;
        end else if (xtal) begin
            total = total + `RCS_FAILSAFE_CYC;
        end
        return rcs_pkg::rcs_count_t'(total);
    endfunction

    // Selected trip comparator, active in run, sleep and idle alike
    wire brownout = borCfgReg[`RCS_BIT_BOR_EN] &
                    brownoutBelow[borCfgReg[1:0]];
    wire coldEvent = powerOnEvent | brownout;
    wire wdogReset = watchdogTimeout & ~inSleep & ~inIdle;
    wire wdogWake  = watchdogTimeout & (inSleep | inIdle);
    wire sleepWake = inSleep & interruptWake;
    wire idleWake  = inIdle & interruptWake;
    wire warmEvent = pinResetReq | wdogReset | softResetReq |
                     trapConflictReq | illegalOpReq;
    wire running   = (stateReg == rcs_pkg::ST_RUN);
    wire wakeEvent = running & (wdogWake | sleepWake | idleWake);
    wire clockReady = oscRunning & (~crystalMode | oscStartupDone) &
                      (~pllUsed | pllLocked);
    wire delayDone = (delayReg == '0);

    wire busReq   = cyc_i & stb_i;
    wire hitReset = (adr_i == `RCS_ADR_RESET_CTRL);
    wire hitOsc   = (adr_i == `RCS_ADR_OSC_CTRL);
    wire hitCfg   = (adr_i == `RCS_ADR_BOR_CFG);
    wire busWrite = busReq & we_i & ackReg;
    wire [15:0] byteMask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [15:0] wrFlags  = (flagsReg & ~byteMask) | (dat_i[15:0] & byteMask);
    wire [15:0] oscView  = {2'h0, clockSource, 6'h00, pllLocked, 1'b0,
                            failReg, 3'h0};
    wire [31:0] readMux  = hitReset ? {16'h0, flagsReg} :
                           hitOsc   ? {16'h0, oscView} :
                           hitCfg   ? {29'h0, borCfgReg} : 32'h0;

    // Clock withheld in reset, unless a fail trap has fired, while start-up timer or PLL lock is pending
    assign clockHold = ~running & ~failReg &
                       ((crystalMode & ~oscStartupDone) |
                        (pllUsed & ~pllLocked));
    assign internalReset = ~running;
    assign ack_o = ackReg;
    assign dat_o = datReg;

    always_comb begin
        // Software write first, so a same-cycle hardware event wins
        flagsBase = (busWrite & hitReset) ? wrFlags : flagsReg;
        flagsNext = flagsBase;
        if (powerOnEvent) begin
            flagsNext = `RCS_RESET_CTRL_RST;
        end else if (brownout) begin
            flagsNext[`RCS_BIT_BOR] = 1'b1;
            flagsNext[`RCS_BIT_POR] = 1'b0;
        end else if (pinResetReq) begin
            flagsNext[`RCS_BIT_PIN]   = 1'b1;
            flagsNext[`RCS_BIT_WDOG]  = 1'b0;
            flagsNext[`RCS_BIT_SLEEP] = inSleep;
            flagsNext[`RCS_BIT_IDLE]  = inIdle & ~inSleep;
            if (!inSleep && !inIdle) begin
                flagsNext[`RCS_BIT_SOFT] = 1'b0;
            end
        end else if (wdogReset) begin
            flagsNext[`RCS_BIT_WDOG]  = 1'b1;
            flagsNext[`RCS_BIT_PIN]   = 1'b0;
            flagsNext[`RCS_BIT_SOFT]  = 1'b0;
            flagsNext[`RCS_BIT_IDLE]  = 1'b0;
            flagsNext[`RCS_BIT_SLEEP] = 1'b0;
        end else if (softResetReq) begin
            flagsNext[`RCS_BIT_SOFT]  = 1'b1;
            flagsNext[`RCS_BIT_PIN]   = 1'b0;
            flagsNext[`RCS_BIT_WDOG]  = 1'b0;
            flagsNext[`RCS_BIT_IDLE]  = 1'b0;
            flagsNext[`RCS_BIT_SLEEP] = 1'b0;
        end else if (trapConflictReq) begin
            flagsNext[`RCS_BIT_TRAP] = 1'b1;
        end else if (illegalOpReq) begin
            flagsNext[`RCS_BIT_ILLOP] = 1'b1;
        end else if (wakeEvent) begin
            flagsNext[`RCS_BIT_SLEEP] = flagsBase[`RCS_BIT_SLEEP] |
                                        inSleep;
            flagsNext[`RCS_BIT_IDLE]  = flagsBase[`RCS_BIT_IDLE] |
                                        (inIdle & ~inSleep);
            flagsNext[`RCS_BIT_WDOG]  = flagsBase[`RCS_BIT_WDOG] |
                                        wdogWake;
        end
    end

    always_comb begin
        stateNext  = stateReg;
        delayNext  = delayReg;
        vectorNext = vectorReg;
        if (coldEvent) begin
            // Delay restarts for as long as the supply stays low
            stateNext  = rcs_pkg::ST_DELAY;
            delayNext  = delayFor(powerupTimerSel, crystalMode);
            vectorNext = `RCS_VEC_RESET;
        end else if (warmEvent) begin
            // A warm reset must not cut short a delay or a stalled clock
            vectorNext = `RCS_VEC_RESET;
            if (stateReg != rcs_pkg::ST_DELAY &&
                stateReg != rcs_pkg::ST_STALL) begin
                stateNext = rcs_pkg::ST_WAITQ1;
            end
        end else begin
            case (stateReg)
                rcs_pkg::ST_DELAY: begin
                    if (!delayDone) begin
                        delayNext = delayReg - 21'h1;
                    end else if (clockReady) begin
                        stateNext = rcs_pkg::ST_WAITQ1;
                    end else if (failsafeClockMonitor) begin
                        stateNext  = rcs_pkg::ST_WAITQ1;
                        vectorNext = `RCS_VEC_CLKFAIL;
                    end else begin
                        stateNext = rcs_pkg::ST_STALL;
                    end
                end
                rcs_pkg::ST_STALL: begin
                    if (clockReady) begin
                        stateNext = rcs_pkg::ST_WAITQ1;
                    end
                end
                rcs_pkg::ST_WAITQ1: begin
                    if (firstPhaseClock) begin
                        stateNext = rcs_pkg::ST_RUN;
                    end
                end
                default: begin
                    stateNext = rcs_pkg::ST_RUN;
                end
            endcase
        end
    end

    wire trapNow = (stateReg == rcs_pkg::ST_DELAY) & delayDone &
                   ~clockReady & failsafeClockMonitor & ~coldEvent &
                   ~warmEvent;
    wire releaseNow = (stateReg == rcs_pkg::ST_WAITQ1) & firstPhaseClock &
                      ~coldEvent & ~warmEvent;
    wire [23:0] wakePc = sleepWake ? interruptVector :
                         pcCurrent + `RCS_PC_STEP;

    always_ff @(posedge clk) begin
        if (srst) begin
            stateReg <= rcs_pkg::ST_DELAY;
            delayReg <= rcs_pkg::rcs_count_t'(`RCS_POR_CYC);
            flagsReg <= `RCS_RESET_CTRL_RST;
            vectorReg <= `RCS_VEC_RESET;
        end else if (clkEn) begin
            stateReg  <= stateNext;
            delayReg  <= delayNext;
            flagsReg  <= flagsNext;
            vectorReg <= vectorNext;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            clockSource     <= 2'h0;
            primaryOscMode  <= 4'h0;
            failReg         <= 1'b0;
            oscStartupStart <= 1'b0;
            clockFailTrap   <= 1'b0;
        end else if (clkEn) begin
            oscStartupStart <= coldEvent & crystalMode;
            clockFailTrap   <= trapNow;
            if (coldEvent) begin
                clockSource    <= oscGroupConfig;
                primaryOscMode <= primaryOscModeConfig;
                failReg        <= 1'b0;
            end else if (trapNow) begin
                clockSource <= `RCS_GRP_FRC;
                failReg     <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pcLoad  <= 1'b0;
            pcValue <= `RCS_VEC_RESET;
        end else if (clkEn) begin
            pcLoad <= releaseNow | (wakeEvent & ~coldEvent & ~warmEvent);
            if (releaseNow) begin
                pcValue <= vectorReg;
            end else if (wakeEvent) begin
                pcValue <= wakePc;
            end
        end
    end

    // Unmapped offsets answer with zero data and ignore writes
    always_ff @(posedge clk) begin
        if (srst) begin
            ackReg    <= 1'b0;
            datReg    <= 32'h0;
            borCfgReg <= `RCS_BOR_CFG_RST;
        end else if (clkEn) begin
            ackReg <= busReq & ~ackReg;
            if (busReq && !ackReg) begin
                datReg <= readMux;
            end
            if (busWrite && hitCfg && sel_i[0]) begin
                borCfgReg <= dat_i[2:0];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence brownSeen_s;
        clkEn && brownout && !powerOnEvent;
    endsequence
    sequence trapFire_s;
        clkEn && trapNow;
    endsequence

    brown_flag_a: assert property (
        brownSeen_s |=> flagsReg[`RCS_BIT_BOR] && !flagsReg[`RCS_BIT_POR])
        else $error("brown-out did not set flag");
    por_flags_a: assert property (
        clkEn && powerOnEvent |=> flagsReg == `RCS_RESET_CTRL_RST)
        else $error("power-on flags wrong");
    trap_switch_a: assert property (
        trapFire_s |=> clockSource == `RCS_GRP_FRC && failReg &&
                       clockFailTrap)
        else $error("trap did not switch to fast RC");
    trap_vector_a: assert property (
        trapFire_s ##0 !(busWrite && hitReset) |=>
        vectorReg == `RCS_VEC_CLKFAIL && $stable(flagsReg))
        else $error("trap vector or flags wrong");
    stall_hold_a: assert property (
        stateReg == rcs_pkg::ST_STALL && !clockReady |=>
        internalReset && stateReg != rcs_pkg::ST_WAITQ1)
        else $error("left reset without clock");
    cold_delay_a: assert property (
        clkEn && coldEvent |=> stateReg == rcs_pkg::ST_DELAY &&
            delayReg == delayFor($past(powerupTimerSel),
                                 $past(crystalMode)))
        else $error("delay not loaded");
    release_q1_a: assert property (
        $rose(running) |-> $past(firstPhaseClock) && pcLoad)
        else $error("release not on first phase");
    soft_flags_a: assert property (
        clkEn && softResetReq && !powerOnEvent && !brownout &&
        !pinResetReq && !wdogReset |=> flagsReg[`RCS_BIT_SOFT] &&
        !flagsReg[`RCS_BIT_PIN] && !flagsReg[`RCS_BIT_SLEEP])
        else $error("software reset flags wrong");
    pin_sleep_a: assert property (
        clkEn && pinResetReq && inSleep && !coldEvent |=>
        flagsReg[`RCS_BIT_PIN] && flagsReg[`RCS_BIT_SLEEP] &&
        !flagsReg[`RCS_BIT_WDOG] && !flagsReg[`RCS_BIT_IDLE])
        else $error("pin reset in sleep flags wrong");
    bus_ack_a: assert property (
        clkEn && busReq && !ackReg |=> ack_o ##1 !(ack_o && $past(clkEn)))
        else $error("bus ack not single cycle");
endmodule

// [test/rcs_reset_ctrl_tb_top.sv]
// Self-checking bench for the reset-cause and start-up controller.
// Assumes rcs_map.svh on the include path; the bench drives every port.
`timescale 1ns/1ps
`include "rcs_map.svh"
module rcs_reset_ctrl_tb_top;
    typedef struct packed {
        logic [15:0] preset;
        logic [2:0]  ev;
        logic        slp;
        logic        idl;
        logic [15:0] flags;
        logic [23:0] pc;
    } rcs_row_s;
    localparam int LIMIT = 30000;
    logic        clk, srst, clkEn, cyc_i, stb_i, we_i, ack_o;
    logic [7:0]  adr_i;
    logic [3:0]  sel_i, brownoutBelow, primaryOscModeConfig, primaryOscMode;
    logic [31:0] dat_i, dat_o, rdData;
    logic        powerOnEvent, pinResetReq, softResetReq, watchdogTimeout;
    logic        illegalOpReq, trapConflictReq, inSleep, inIdle;
    logic        interruptWake, failsafeClockMonitor, crystalMode, pllUsed;
    logic        oscRunning, oscStartupDone, pllLocked, firstPhaseClock;
    logic        internalReset, clockHold, oscStartupStart, clockFailTrap;
    logic        pcLoad;
    logic [23:0] interruptVector, pcCurrent, pcValue, lastPc;
    logic [1:0]  powerupTimerSel, oscGroupConfig, clockSource;
    logic [1:0]  q1Div = 2'h0;
    int          pcCount = 0, osCount = 0, trapCount = 0, cycles = 0;
    int          miscompares = 0, checksDone = 0, n, s;
    // Tags per row
    rcs_row_s rows [10] = '{
        '{16'hc0df, 3'h0, 1'b0, 1'b0, 16'hc083, 24'h000000},
        '{16'hc0df, 3'h0, 1'b1, 1'b0, 16'hc0cb, 24'h000000},
        '{16'hc0df, 3'h0, 1'b0, 1'b1, 16'hc0c7, 24'h000000},
        '{16'hc0df, 3'h1, 1'b0, 1'b0, 16'hc043, 24'h000000},
        '{16'hc0df, 3'h2, 1'b0, 1'b0, 16'hc013, 24'h000000},
        '{16'h0000, 3'h3, 1'b0, 1'b0, 16'h8000, 24'h000000},
        '{16'h0000, 3'h4, 1'b0, 1'b0, 16'h4000, 24'h000000},
        '{16'hc0dd, 3'h5, 1'b0, 1'b0, 16'hc0de, 24'h000000},
        '{16'h0000, 3'h2, 1'b1, 1'b0, 16'h0018, 24'h001232},
        '{16'h0000, 3'h6, 1'b1, 1'b0, 16'h0008, 24'h000040}};

    rcs_reset_ctrl #(.POWERUP_TIMER_A_CYC(20), .POWERUP_TIMER_B_CYC(40), .POWERUP_TIMER_C_CYC(80)) uut (
        .clk, .srst, .clkEn, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
        .dat_o, .ack_o, .powerOnEvent, .brownoutBelow, .pinResetReq,
        .softResetReq, .watchdogTimeout, .illegalOpReq, .trapConflictReq,
        .inSleep, .inIdle, .interruptWake, .interruptVector, .pcCurrent,
        .failsafeClockMonitor, .powerupTimerSel, .oscGroupConfig,
        .primaryOscModeConfig, .crystalMode, .pllUsed, .oscRunning,
        .oscStartupDone, .pllLocked, .firstPhaseClock, .internalReset,
        .clockHold, .oscStartupStart, .clockFailTrap, .clockSource,
        .primaryOscMode, .pcLoad, .pcValue);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checksDone, miscompares);
        if (miscompares == 0 && checksDone > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // First-phase strobe every fourth cycle, like an instruction cycle
    always @(posedge clk) begin
        q1Div <= q1Div + 2'h1;
        firstPhaseClock <= (q1Div == 2'h3);
        if (pcLoad === 1'b1) begin
            pcCount <= pcCount + 1;
            lastPc <= pcValue;
        end
        if (oscStartupStart === 1'b1) osCount <= osCount + 1;
        if (clockFailTrap === 1'b1) trapCount <= trapCount + 1;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic checkV(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic checkB(input logic got, input logic exp);
        checksDone++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // Holds the request until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        sel_i <= 4'hf;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk);
        while (ack_o !== 1'b1) @(posedge clk);
        rdData = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        checkV(rdData, exp);
    endtask

    task automatic fire(input logic [2:0] ev);
        @(posedge clk);
        case (ev)
            3'h0: pinResetReq <= 1'b1;
            3'h1: softResetReq <= 1'b1;
            3'h2: watchdogTimeout <= 1'b1;
            3'h3: trapConflictReq <= 1'b1;
            3'h4: illegalOpReq <= 1'b1;
            3'h5: brownoutBelow <= 4'hf;
            3'h6: interruptWake <= 1'b1;
            default: powerOnEvent <= 1'b1;
        endcase
        @(posedge clk);
        {pinResetReq, softResetReq, watchdogTimeout, trapConflictReq} <= '0;
        {illegalOpReq, interruptWake, powerOnEvent} <= '0;
        brownoutBelow <= 4'h0;
    endtask

    // Waits for a vector load with the core out of reset, bounded
    task automatic waitPc(input int startCnt);
        int k;
        k = 0;
        while (k < 4000 &&
               !(pcCount != startCnt && internalReset === 1'b0)) begin
            @(posedge clk);
            k++;
        end
        checkB(k < 4000, 1'b1);
    endtask

    initial begin
        {clkEn, srst, oscRunning, oscStartupDone, pllLocked} = 5'h1f;
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} = {43'h0, 4'hf};
        {powerOnEvent, pinResetReq, softResetReq, watchdogTimeout} = 4'h0;
        {illegalOpReq, trapConflictReq, inSleep, inIdle} = 4'h0;
        {interruptWake, failsafeClockMonitor, crystalMode, pllUsed} = 4'h0;
        {brownoutBelow, powerupTimerSel, oscGroupConfig} = 8'h00;
        primaryOscModeConfig = 4'h0;
        interruptVector = 24'h000040;
        pcCurrent = 24'h001230;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (240) @(posedge clk);
        checkB(internalReset, 1'b1);
        waitPc(0);
        checkV({8'h00, lastPc}, 32'h0);
        rd(`RCS_ADR_RESET_CTRL, 32'h3);
        rd(`RCS_ADR_BOR_CFG, 32'h4);
        rd(8'h0c, 32'h0);
        foreach (rows[i]) begin
            wb(1'b1, `RCS_ADR_RESET_CTRL, {16'h0, rows[i].preset});
            rd(`RCS_ADR_RESET_CTRL, {16'h0, rows[i].preset});
            inSleep <= rows[i].slp;
            inIdle <= rows[i].idl;
            n = pcCount;
            fire(rows[i].ev);
            waitPc(n);
            inSleep <= 1'b0;
            inIdle <= 1'b0;
            rd(`RCS_ADR_RESET_CTRL, {16'h0, rows[i].flags});
            checkV({8'h00, lastPc}, {8'h00, rows[i].pc});
        end
        // Trip level two: supply below the top level only must not trip
        wb(1'b1, `RCS_ADR_BOR_CFG, 32'h6);
        wb(1'b1, `RCS_ADR_RESET_CTRL, 32'h0);
        powerupTimerSel <= 2'h2;
        brownoutBelow <= 4'h8;
        repeat (10) @(posedge clk);
        checkB(internalReset, 1'b0);
        inSleep <= 1'b1;
        n = pcCount;
        fire(3'h5);
        repeat (280) @(posedge clk);
        checkB(internalReset, 1'b1);
        waitPc(n);
        inSleep <= 1'b0;
        powerupTimerSel <= 2'h0;
        rd(`RCS_ADR_RESET_CTRL, 32'h2);
        // Crystal never starts with the monitor on: trap to fast RC
        {oscGroupConfig, primaryOscModeConfig} <= 6'h15;
        {crystalMode, failsafeClockMonitor} <= 2'h3;
        {oscRunning, oscStartupDone} <= 2'h0;
        n = pcCount;
        s = osCount;
        fire(3'h7);
        repeat (10) @(posedge clk);
        checkV({30'h0, clockSource}, 32'h1);
        checkV({28'h0, primaryOscMode}, 32'h5);
        checkV(32'(osCount - s), 32'h1);
        repeat (2590) @(posedge clk);
        checkB(internalReset, 1'b1);
        waitPc(n);
        checkV(32'(trapCount), 32'h1);
        checkV({30'h0, clockSource}, {30'h0, `RCS_GRP_FRC});
        checkV({8'h00, lastPc}, 32'h4);
        rd(`RCS_ADR_RESET_CTRL, 32'h3);
        rd(`RCS_ADR_OSC_CTRL, 32'h2028);
        // Monitor off and no clock: stall until the clock runs
        {crystalMode, failsafeClockMonitor} <= 2'h0;
        n = pcCount;
        fire(3'h7);
        repeat (400) @(posedge clk);
        checkB(internalReset, 1'b1);
        {oscRunning, oscStartupDone} <= 2'h3;
        waitPc(n);
        checkV({8'h00, lastPc}, 32'h0);
        // Frozen block must ignore an event pulse
        clkEn <= 1'b0;
        fire(3'h1);
        repeat (4) @(posedge clk);
        checkB(internalReset, 1'b0);
        clkEn <= 1'b1;
        rd(`RCS_ADR_RESET_CTRL, 32'h3);
        // Brown-out with crystal and PLL: held by timer, then by lock
        {crystalMode, pllUsed, pllLocked, oscStartupDone} <= 4'hc;
        n = pcCount;
        s = osCount;
        fire(3'h5);
        repeat (3000) @(posedge clk);
        checkB(clockHold, 1'b1);
        checkV(32'(osCount - s), 32'h1);
        oscStartupDone <= 1'b1;
        repeat (20) @(posedge clk);
        checkB(clockHold, 1'b1);
        checkB(internalReset, 1'b1);
        rd(`RCS_ADR_OSC_CTRL, 32'h1000);
        pllLocked <= 1'b1;
        waitPc(n);
        checkB(clockHold, 1'b0);
        // Mid-run reset restores the power-on flags and delay
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        checkB(internalReset, 1'b1);
        srst <= 1'b0;
        rd(`RCS_ADR_RESET_CTRL, 32'h3);
        n = pcCount;
        waitPc(n);
        wrap_up();
    end
endmodule
